// >>> logic/dac_loader_regs.vh
// constants for the reference dac serial loader
`ifndef DAC_LOADER_REGS_VH
`define DAC_LOADER_REGS_VH
// register byte offsets
`define CTRL_OFS        8'h00
`define STATUS_OFS      8'h04
`define LAST_WORD_OFS   8'h08
`define REFRESH_OFS     8'h0C
`define CODE_BASE_OFS   8'h40
`define CODE_END_OFS    8'h88
// control fields and reset value
`define CTRL_SRC_BIT    0
`define CTRL_DRIVE_BIT  1
`define CTRL_RESET      2'h0
// serial word layout
`define WORD_BITS       16
`define ADDR_MSB        14
`define ADDR_LSB        10
`define CODE_MSB        9
`define CODE_LSB        0
`define CHAN_COUNT      5'h12
`define BIT_CNT_MAX     6'h3F
`define WORD_BITS_CNT   6'h10
// axi responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
// timing
`define CLK_FREQ_HZ     10000000
`define OSC_FREQ_HZ     21000
`define SCLK_MAX_HZ     5000000
`define OSC_HALF_CYC    (`CLK_FREQ_HZ / (2 * `OSC_FREQ_HZ))
`endif

// >>> logic/pin_sync.v
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter INIT = 1'b0           // level shown during reset
) (
  // clock and reset
  input  wire aclk,
  input  wire aresetn,
  // pin side
  input  wire pin_in,
  // filtered level
  output reg  level_r
);
  reg ff1_r;                      // metastable stage, read only by ff2
  reg ff2_r;                      // second stage
  reg ff3_r;                      // third stage

  // level changes only once stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      ff1_r   <= INIT;
      ff2_r   <= INIT;
      ff3_r   <= INIT;
      level_r <= INIT;
    end else begin
      ff1_r <= pin_in;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      if (ff2_r == ff3_r) begin
        level_r <= ff3_r;
      end
    end
  end
endmodule // pin_sync
`default_nettype wire

// >>> logic/code_store.v
// storage of the per-channel output codes, two read ports
`include "dac_loader_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module code_store (
  // clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // write port
  input  wire       wr_en,
  input  wire [4:0] wr_chan,
  input  wire [9:0] wr_code,
  // read ports, combinational
  input  wire [4:0] rd_a_chan,
  output wire [9:0] rd_a_code,
  input  wire [4:0] rd_b_chan,
  output wire [9:0] rd_b_code
);
  reg [9:0] code_mem [0:17];      // one code per channel
  integer   i;

  // codes clear to zero so outputs start at the low reference
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 18; i = i + 1) begin
        code_mem[i] <= 10'h000;
      end
    end else if (wr_en && (wr_chan < `CHAN_COUNT)) begin
      code_mem[wr_chan] <= wr_code;
    end
  end

  // out-of-range reads return zero
  assign rd_a_code = (rd_a_chan < `CHAN_COUNT) ? code_mem[rd_a_chan] : 10'h000;
  assign rd_b_code = (rd_b_chan < `CHAN_COUNT) ? code_mem[rd_b_chan] : 10'h000;
endmodule // code_store
`default_nettype wire

// >>> logic/reference_dac_serial_loader.v
// serial loader, refresh sequencer and axi4-lite registers
`include "dac_loader_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module reference_dac_serial_loader (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  // axi4-lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // axi4-lite read address
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  // axi4-lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // serial link pins
  input  wire        load_enable_n,
  input  wire        serial_clock,
  input  wire        serial_in,
  output reg         serial_out,
  // refresh clock pin, split three ways
  input  wire        refresh_clock_pin_in,
  output wire        refresh_clock_pin_out,
  output wire        refresh_clock_pin_oe,
  // refresh stage towards the hold amplifiers
  output reg  [4:0]  refresh_chan,
  output reg  [9:0]  refresh_code,
  output reg         refresh_strobe
);
  localparam integer OSC_HALF_INT = `OSC_HALF_CYC;     // half period, aclk
  localparam [8:0]   OSC_HALF     = OSC_HALF_INT[8:0]; // internal half period

  // synchronised pin levels
  wire ena_n_s;                   // filtered enable
  wire sclk_s;                    // filtered serial clock
  wire sdi_s;                     // filtered serial data
  wire refresh_clock_pin_s;                 // filtered external refresh clock

  // serial state
  reg        sclk_prev_r;         // serial clock last cycle
  reg        ena_prev_r;          // enable last cycle
  reg [15:0] shift_r;             // the 16-bit shift register
  reg [5:0]  bit_cnt_r;           // bits shifted this frame, saturating
  reg [15:0] last_word_r;         // word latched at last enable rise
  reg        bad_addr_r;          // last word named no channel
  reg        short_r;             // last frame had under 16 bits

  // control and refresh state
  reg [1:0]  ctrl_r;              // source select and pin drive
  reg [8:0]  osc_cnt_r;           // internal oscillator divider
  reg        osc_r;               // internal oscillator level
  reg        refclk_prev_r;       // selected refresh clock last cycle
  reg [4:0]  seq_chan_r;          // next channel to refresh

  // bus state
  reg        aw_held_r;           // write address captured
  reg [7:0]  aw_addr_r;           // captured write address
  reg        w_held_r;            // write data captured
  reg [31:0] w_data_r;            // captured write data
  reg [3:0]  w_strb_r;            // captured byte enables

  // decode helpers
  wire       sclk_rise;           // rising serial clock edge
  wire       sclk_fall;           // falling serial clock edge
  wire       ena_rise;            // enable returning high
  wire [4:0] word_addr;           // channel field of shifted word
  wire       word_ok;             // full word with a real channel
  wire       refclk;              // selected refresh clock
  wire       refclk_fall;         // refresh clock falling edge
  wire [9:0] seq_code;            // code of channel being refreshed
  wire [9:0] bus_code;            // code read over the bus
  wire [4:0] bus_chan;            // channel index from read address
  wire       rd_in_codes;         // read address in code window
  wire       do_write;            // both write halves present
  wire [7:0] code_ofs;            // read offset into code window

  // pin synchronisers; enable idles high, others low
  pin_sync #(.INIT(1'b1)) u_sync_ena (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (load_enable_n),
    .level_r (ena_n_s)
  );
  pin_sync #(.INIT(1'b0)) u_sync_sclk (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (serial_clock),
    .level_r (sclk_s)
  );
  pin_sync #(.INIT(1'b0)) u_sync_sdi (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (serial_in),
    .level_r (sdi_s)
  );
  pin_sync #(.INIT(1'b0)) u_sync_osc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (refresh_clock_pin_in),
    .level_r (refresh_clock_pin_s)
  );

  // edges count only while the frame is open
  // serial clock must run well below aclk/4 for the filter
  assign sclk_rise = !ena_n_s && sclk_s && !sclk_prev_r;
  assign sclk_fall = !ena_n_s && !sclk_s && sclk_prev_r;
  assign ena_rise  = ena_n_s && !ena_prev_r;

  // field split of the completed word
  assign word_addr = shift_r[`ADDR_MSB:`ADDR_LSB];
  // top bit is a test bit and is not looked at
  assign word_ok   = (bit_cnt_r >= `WORD_BITS_CNT)
                   && (word_addr < `CHAN_COUNT);

  // edge history for the serial pins
  always @(posedge aclk) begin
    if (!aresetn) begin
      sclk_prev_r <= 1'b0;
      ena_prev_r  <= 1'b1;
    end else begin
      sclk_prev_r <= sclk_s;
      ena_prev_r  <= ena_n_s;
    end
  end

  // shift register and bit counter
  always @(posedge aclk) begin
    if (!aresetn) begin
      shift_r   <= 16'h0000;
      bit_cnt_r <= 6'h00;
    end else if (sclk_rise) begin
      // new bit enters at the bottom, so first bit ends on top
      shift_r <= {shift_r[14:0], sdi_s};
      if (bit_cnt_r != `BIT_CNT_MAX) begin
        bit_cnt_r <= bit_cnt_r + 6'h01;
      end
    end else if (ena_rise) begin
      // a fresh frame starts counting again
      bit_cnt_r <= 6'h00;
    end
  end

  // serial output changes on falling edges only
  // a chain passes older words downstream this way
  always @(posedge aclk) begin
    if (!aresetn) begin
      serial_out <= 1'b0;
    end else if (sclk_fall) begin
      serial_out <= shift_r[`WORD_BITS-1];
    end
  end

  // frame close: capture word and status
  // every chained part sees the same enable edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      last_word_r <= 16'h0000;
      bad_addr_r  <= 1'b0;
      short_r     <= 1'b0;
    end else if (ena_rise) begin
      last_word_r <= shift_r;
      bad_addr_r  <= (word_addr >= `CHAN_COUNT);
      short_r     <= (bit_cnt_r < `WORD_BITS_CNT);
    end
  end

  // channel codes; the write is the enable rise itself
  code_store u_store (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .wr_en     (ena_rise && word_ok),
    .wr_chan   (word_addr),
    .wr_code   (shift_r[`CODE_MSB:`CODE_LSB]),
    .rd_a_chan (seq_chan_r),
    .rd_a_code (seq_code),
    .rd_b_chan (bus_chan),
    .rd_b_code (bus_code)
  );

  // internal refresh oscillator, free running divider
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt_r <= 9'h000;
      osc_r     <= 1'b0;
    end else if (osc_cnt_r == OSC_HALF - 9'h001) begin
      osc_cnt_r <= 9'h000;
      osc_r     <= !osc_r;
    end else begin
      osc_cnt_r <= osc_cnt_r + 9'h001;
    end
  end

  // source choice; reset value picks internal
  assign refclk = ctrl_r[`CTRL_SRC_BIT] ? refresh_clock_pin_s : osc_r;

  // pin driven only in internal mode once software allows it
  // drive gate keeps the pin quiet after reset
  assign refresh_clock_pin_oe  = !ctrl_r[`CTRL_SRC_BIT]
                               && ctrl_r[`CTRL_DRIVE_BIT];
  assign refresh_clock_pin_out = osc_r;

  assign refclk_fall = !refclk && refclk_prev_r;

  // refresh sequencer, one channel per falling refresh edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      refclk_prev_r  <= 1'b0;
      seq_chan_r     <= 5'h00;
      refresh_chan   <= 5'h00;
      refresh_code   <= 10'h000;
      refresh_strobe <= 1'b0;
    end else begin
      refclk_prev_r  <= refclk;
      refresh_strobe <= refclk_fall;
      if (refclk_fall) begin
        refresh_chan <= seq_chan_r;
        refresh_code <= seq_code;
        // wrap after the last channel, 18 clocks a turn
        if (seq_chan_r == `CHAN_COUNT - 5'h01) begin
          seq_chan_r <= 5'h00;
        end else begin
          seq_chan_r <= seq_chan_r + 5'h01;
        end
      end
    end
  end

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready  = !w_held_r;
  assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;

  // capture of the two write halves and the response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r    <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_held_r     <= 1'b0;
      w_data_r     <= 32'h00000000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        // halves released together with the response
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // only control is writable; the rest answers slave error
        if (aw_addr_r == `CTRL_OFS) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control register, low byte lane only
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `CTRL_RESET;
    end else if (do_write && (aw_addr_r == `CTRL_OFS) && w_strb_r[0]) begin
      ctrl_r <= w_data_r[1:0];
    end
  end

  // read channel: one read in flight, answered next cycle
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_in_codes   = (s_axi_araddr >= `CODE_BASE_OFS)
                       && (s_axi_araddr < `CODE_END_OFS);
  // code window starts mid-way in the map, so rebase before indexing
  assign code_ofs      = s_axi_araddr - `CODE_BASE_OFS;
  assign bus_chan      = rd_in_codes ? code_ofs[6:2] : 5'h1F;

  // read data mux, unused bits read zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      case (s_axi_araddr)
        `CTRL_OFS: begin
          s_axi_rdata <= {30'h0000000, ctrl_r};
        end
        `STATUS_OFS: begin
          s_axi_rdata <= {20'h00000, ctrl_r[`CTRL_SRC_BIT], short_r,
                          bad_addr_r, !ena_n_s, 2'h0, bit_cnt_r};
        end
        `LAST_WORD_OFS: begin
          s_axi_rdata <= {16'h0000, last_word_r};
        end
        `REFRESH_OFS: begin
          s_axi_rdata <= {27'h000000, seq_chan_r};
        end
        default: begin
          // code window or nothing at all
          if (rd_in_codes) begin
            s_axi_rdata <= {22'h00000, bus_code};
          end else begin
            s_axi_rresp <= `RESP_SLVERR;
          end
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // reference_dac_serial_loader
`default_nettype wire

// >>> dv/loader_monitor.sv
// port checker for the serial loader
`timescale 1ns/1ps
`default_nettype none
module loader_monitor (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // register bus
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  // link and refresh
  input wire logic       load_enable_n,
  input wire logic       serial_out,
  input wire logic       refresh_clock_pin_oe,
  input wire logic [4:0] refresh_chan,
  input wire logic       refresh_strobe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [4:0] last_chan_r;  // channel of previous refresh
  logic       seen_r;       // a refresh has happened since reset
  // remember the last refreshed channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_r      <= 1'b0;
      last_chan_r <= 5'h00;
    end else if (refresh_strobe) begin
      seen_r      <= 1'b1;
      last_chan_r <= refresh_chan;
    end
  end
  chk_write_ans: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_read_ans: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer open");
  chk_strobe_pulse: assert property (refresh_strobe |=> !refresh_strobe)
    else $error("refresh strobe too long");
  chk_chan_range: assert property (refresh_strobe |-> refresh_chan < 5'h12)
    else $error("refresh channel out of range");
  chk_chan_step: assert property (refresh_strobe && seen_r |-> refresh_chan ==
    ((last_chan_r == 5'h11) ? 5'h00 : last_chan_r + 5'h01))
    else $error("refresh order broken");
  chk_sdo_idle: assert property (load_enable_n [*8] |=> $stable(serial_out))
    else $error("serial output moved while disabled");
  chk_pin_quiet: assert property ($rose(aresetn) |-> !refresh_clock_pin_oe)
    else $error("refresh pin driven after reset");
  // main scenarios reached
  cover property (s_axi_bvalid);
  cover property (refresh_strobe && refresh_chan == 5'h11);
  cover property (!load_enable_n && serial_out);
endmodule // loader_monitor
bind reference_dac_serial_loader loader_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .load_enable_n(load_enable_n), .serial_out(serial_out),
  .refresh_clock_pin_oe(refresh_clock_pin_oe),
  .refresh_chan(refresh_chan), .refresh_strobe(refresh_strobe));
`default_nettype wire

// >>> dv/serial_host.sv
// host serial master model for the three-wire load link
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  // timing reference
  input  wire logic aclk,
  // link pins
  output var  logic load_enable_n,
  output var  logic serial_clock,
  output var  logic serial_in,
  input  wire logic serial_out
);
  logic [31:0] sdo_seen;  // output bits, one per rise
  // idle link: clock low, enable high
  initial begin
    load_enable_n = 1'b1;
    serial_clock  = 1'b0;
    serial_in     = 1'b0;
    sdo_seen      = 32'h0;
  end
  // one frame of n bits, msb first, 800 ns a bit
  task automatic send(input logic [31:0] w, input int n);
    serial_clock  <= 1'b0;
    load_enable_n <= 1'b0;
    repeat (4) @(posedge aclk);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in <= w[i];
      repeat (4) @(posedge aclk);
      serial_clock <= 1'b1;  // 800 ns period
      // sample late in the high phase, well after the output settles
      repeat (3) @(posedge aclk);
      sdo_seen <= {sdo_seen[30:0], serial_out};
      @(posedge aclk);
      serial_clock <= 1'b0;
    end
    repeat (4) @(posedge aclk);
    load_enable_n <= 1'b1;
    serial_in     <= ~serial_in;  // released line shows no stale level
    repeat (8) @(posedge aclk);
  endtask
  // stray clocks with enable high, which must be ignored
  task automatic stray(input int n);
    repeat (n) begin
      serial_in    <= ~serial_in;
      serial_clock <= 1'b1;
      repeat (4) @(posedge aclk);
      serial_clock <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask
endmodule // serial_host
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench: registers, serial loads, refresh
`timescale 1ns/1ps
`default_nettype none
`include "dac_loader_regs.vh"
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_errors++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;  // always accepting
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, serial_out, refresh_strobe;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic load_enable_n, serial_clock, serial_in;
  logic refresh_clock_pin_out, refresh_clock_pin_oe, refresh_clock_pin_in;
  logic [4:0] refresh_chan;
  logic [9:0] refresh_code;
  logic refresh_clock_pin = 1'b0, osc_run = 1'b0;
  logic [2:0] oc = 3'h0;
  logic [9:0] exp_code [18] = '{default: 10'h000};
  logic [15:0] words [4] =  // top bit always zero
    '{16'h03FF, 16'h0E01, 16'h1C1F, 16'h441F};
  int n_errors = 0, n_compared = 0, t;
  always #50 aclk = ~aclk;
  // far refresh clock, 16 aclk a period; the device wins when driving
  always @(posedge aclk) begin
    oc <= oc + 3'h1;
    if (osc_run && oc == 3'h7) refresh_clock_pin <= ~refresh_clock_pin;
  end
  assign refresh_clock_pin_in = refresh_clock_pin_oe ?
                                refresh_clock_pin_out : refresh_clock_pin;
  reference_dac_serial_loader u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .load_enable_n(load_enable_n), .serial_clock(serial_clock),
    .serial_in(serial_in), .serial_out(serial_out),
    .refresh_clock_pin_in(refresh_clock_pin_in),
    .refresh_clock_pin_out(refresh_clock_pin_out),
    .refresh_clock_pin_oe(refresh_clock_pin_oe),
    .refresh_chan(refresh_chan), .refresh_code(refresh_code),
    .refresh_strobe(refresh_strobe));
  serial_host u_host (.aclk(aclk), .load_enable_n(load_enable_n),
    .serial_clock(serial_clock), .serial_in(serial_in),
    .serial_out(serial_out));
  task automatic results;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bound(input int lim);
    if (t >= lim) begin
      n_errors++;
      results();
    end
  endtask
  function automatic logic [7:0] ca(input logic [4:0] c);
    return `CODE_BASE_OFS + {1'b0, c, 2'h0};
  endfunction
  // one write, both halves offered at once
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    t = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && t < 99);
    bound(99);
    `CHECK("bresp", er, s_axi_bresp)
  endtask
  // one read, masked compare of data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, input logic [1:0] er);
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && t < 99);
    bound(99);
    `CHECK("rdata", e, s_axi_rdata & m)
    `CHECK("rresp", er, s_axi_rresp)
  endtask
  // wait for a refresh and compare its code
  task automatic strobe_chk(input int lim);
    t = 0;
    do begin
      @(posedge aclk);
      t++;
    end while (!refresh_strobe && t < lim);
    bound(lim);
    `CHECK("refresh code", exp_code[refresh_chan], refresh_code)
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(`CTRL_OFS, 32'h0, 32'hFFFFFFFF, `RESP_OKAY);
    `CHECK("pin off", 1'b0, refresh_clock_pin_oe)
    rd(8'h10, 32'h0, 32'hFFFFFFFF, `RESP_SLVERR);
    axw(`STATUS_OFS, 32'h1, `RESP_SLVERR);
    // plain words, address and code fields
    for (int i = 0; i < 4; i++) begin
      u_host.send({16'h0, words[i]}, 16);
      exp_code[words[i][14:10]] = words[i][9:0];
      rd(ca(words[i][14:10]), {22'h0, words[i][9:0]}, 32'h3FF, `RESP_OKAY);
    end
    // address 18 is discarded
    u_host.send({16'h0, 16'h4955}, 16);
    rd(ca(5'h02), 32'h0, 32'h3FF, `RESP_OKAY);
    rd(ca(5'h00), 32'h3FF, 32'h3FF, `RESP_OKAY);
    rd(`STATUS_OFS, 32'h200, 32'h200, `RESP_OKAY);
    rd(`LAST_WORD_OFS, 32'h4955, 32'hFFFF, `RESP_OKAY);
    // short frame writes nothing
    u_host.send({16'h0, 16'h0555}, 15);
    rd(ca(5'h01), 32'h0, 32'h3FF, `RESP_OKAY);
    rd(`STATUS_OFS, 32'h400, 32'h400, `RESP_OKAY);
    // two words in one frame: last one stays, first passes on
    u_host.send({16'h16AA, 16'h1955}, 32);
    exp_code[6] = 10'h155;
    rd(ca(5'h06), 32'h155, 32'h3FF, `RESP_OKAY);
    rd(ca(5'h05), 32'h0, 32'h3FF, `RESP_OKAY);
    `CHECK("chain out", 16'h16AA, u_host.sdo_seen[15:0])
    // clocks while disabled must not shift
    u_host.stray(6);
    u_host.send({16'h0, 16'h20F0}, 16);
    exp_code[8] = 10'h0F0;
    `CHECK("held word", 16'h1955, u_host.sdo_seen[15:0])
    rd(ca(5'h08), 32'h0F0, 32'h3FF, `RESP_OKAY);
    // internal source, pin driven
    axw(`CTRL_OFS, 32'h2, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHECK("pin drive", 1'b1, refresh_clock_pin_oe)
    strobe_chk(1200);
    `CHECK("pin level", 1'b0, refresh_clock_pin_out)
    // external source: still pin gives no refresh
    axw(`CTRL_OFS, 32'h1, `RESP_OKAY);
    repeat (20) @(posedge aclk);
    `CHECK("pin free", 1'b0, refresh_clock_pin_oe)
    t = 0;
    repeat (1500) begin
      @(posedge aclk);
      if (refresh_strobe) t++;
    end
    `CHECK("still refresh", 0, t)
    osc_run <= 1'b1;
    repeat (18) strobe_chk(60);
    results();
  end
endmodule // testbench
`default_nettype wire
